// ==== shared/trig_seq_map.vh ====
// Register map, field layout, reset values and timing for the trigger sequencer
`ifndef TRIG_SEQ_MAP_VH
`define TRIG_SEQ_MAP_VH

`define ADDR_W 8
`define DATA_W 32

`define REG_CTRL 8'h00
`define REG_ARM_CFG 8'h04
`define REG_SCAN_CFG 8'h08
`define REG_CHAN_CFG 8'h0C
`define REG_SETTLE 8'h10
`define REG_DELAY 8'h14
`define REG_LIST_LEN 8'h18
`define REG_LIST_DATA 8'h1C
`define REG_LIST_PTR 8'h20
`define REG_STATUS 8'h24

`define CTRL_STEP 0
`define CTRL_ABORT 1
`define CTRL_CLR_ERR 2

`define F_SP_HI 1
`define F_SP_LO 0
`define F_CTL 2
`define F_MODE 3
`define F_CNT_HI 15
`define F_CNT_LO 8
`define F_IN_HI 18
`define F_IN_LO 16
`define F_OUT_HI 22
`define F_OUT_LO 20

`define SP_IMM 2'h0
`define SP_EXT 2'h1
`define SP_BUS 2'h2

`define NUM_LINES 6
`define LINE_MAX 3'h5

`define ARM_CFG_RST 32'h0010_0100
`define SCAN_CFG_RST 32'h0010_0100
`define CHAN_CFG_RST 32'h0001_0004

`define CLK_PERIOD_NS 8
`define OUT_PULSE_NS 10000

`endif

// ==== verilog/list_mem.v ====
// Scan list storage with registered read data
`timescale 1ns/10ps
`default_nettype none
module list_mem #(
  parameter DW = 8,
  parameter AW = 8
) (
  input wire clk,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data_ff
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_ff <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// ==== verilog/scan_trigger_sequencer.v ====
// Three-layer scan trigger sequencer with external and bus triggers
//
// Function
// - Each falling edge on the external trigger input makes one event; the code makes none for a low not sampled on two successive clocks.
// - External events only act in layers whose spacing selects external.
// - Channel spacing external: pulse after each channel closes and settles.
// - Scan return pass pulses when scan control is source and spacing external.
// - Arm return pass pulses when arm control is source and spacing external.
// - Control set to source skips a layer's first trigger wait.
// - Immediate arm and scan spacing leave idle on step without waiting.
// - Step closes first list channel; each channel trigger closes the next.
// - Six trigger bus lines, each usable as input or output.
// - Asynchronous mode uses separate lines; semi-synchronous mode gives the channel layer no bus input or output.
// - Asynchronous bus pulses match external input and output pulse form.
// - Any of six lines per layer; same input and output line is refused.
// - Bus channel spacing: input closes channel, pulse after settle.
// - Channel layer takes bus inputs only with bus channel spacing.
// - Scan and arm layers may use bus lines, shareable with channel.
// - Reset sets immediate arm/scan, arm count 1, acceptors, channel source.
// - Source bypass only on the initial pass; later loops wait.
// - Channel bypass is re-enabled at the start of each scan.
// - After the last channel of the last scan, return to idle.
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "trig_seq_map.vh"
module scan_trigger_sequencer #(
  parameter LIST_AW = 8,
  parameter PULSE_CYC = (`OUT_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input wire clk,
  input wire rst,
  input wire [`ADDR_W-1:0] addr,
  input wire [`DATA_W-1:0] wdata,
  input wire wr,
  input wire rd,
  output reg [`DATA_W-1:0] rdata_ff,
  input wire ext_trig_n,
  output reg chan_ready_n_ff,
  input wire [`NUM_LINES-1:0] bus_in,
  output reg [`NUM_LINES-1:0] bus_out_ff,
  output reg [`NUM_LINES-1:0] bus_oe_ff,
  output reg chan_close_ff,
  output reg [7:0] chan_num_ff,
  output reg idle_ff
);
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_ARM_W = 4'h1;
  localparam [3:0] ST_SCAN_W = 4'h2;
  localparam [3:0] ST_CHAN_W = 4'h3;
  localparam [3:0] ST_FETCH = 4'h4;
  localparam [3:0] ST_CLOSE = 4'h5;
  localparam [3:0] ST_SETTLE = 4'h6;
  localparam [3:0] ST_CHAN_OUT = 4'h7;
  localparam [3:0] ST_SCAN_END = 4'h8;
  localparam [3:0] ST_SCAN_OUT = 4'h9;
  localparam [3:0] ST_ARM_END = 4'hA;
  localparam [3:0] ST_ARM_OUT = 4'hB;
  localparam [15:0] PULSE_LEN = PULSE_CYC[15:0];
  localparam NIN = `NUM_LINES + 1;

  reg [3:0] state_ff;
  reg [`DATA_W-1:0] arm_cfg_ff;
  reg [`DATA_W-1:0] scan_cfg_ff;
  reg [`DATA_W-1:0] chan_cfg_ff;
  reg [15:0] settle_ff;
  reg [15:0] delay_ff;
  reg [LIST_AW:0] list_len_ff;
  reg [LIST_AW-1:0] list_ptr_ff;
  reg cfg_err_ff;
  reg arm_first_ff;
  reg scan_first_ff;
  reg chan_first_ff;
  reg [7:0] arm_left_ff;
  reg [7:0] scan_left_ff;
  reg [LIST_AW:0] chan_left_ff;
  reg [LIST_AW-1:0] chan_idx_ff;
  reg [16:0] timer_ff;
  reg [15:0] pulse_cnt_ff;
  reg [NIN-1:0] sync1_ff;
  reg [NIN-1:0] sync2_ff;
  reg [NIN-1:0] sync3_ff;
  reg [NIN-1:0] stable_ff;
  wire [NIN-1:0] raw_in;
  wire [NIN-1:0] fall;
  wire [7:0] mem_q;
  wire mem_we;
  wire step_cmd;
  wire abort_cmd;
  wire clr_err;
  wire arm_go;
  wire scan_go;
  wire chan_go;
  wire [LIST_AW:0] chan_total;
  wire [LIST_AW-1:0] nxt_idx;

  // Line pair valid: both in range and distinct
  function line_ok;
    input [`DATA_W-1:0] cfg;
    reg [2:0] li;
    reg [2:0] lo;
    begin
      li = cfg[`F_IN_HI:`F_IN_LO];
      lo = cfg[`F_OUT_HI:`F_OUT_LO];
      line_ok = (li != lo) && (li <= `LINE_MAX) && (lo <= `LINE_MAX);
    end
  endfunction

  // Trigger event seen by a layer from its selected source
  function layer_ev;
    input [`DATA_W-1:0] cfg;
    input ext_ev;
    input [`NUM_LINES-1:0] bus_ev;
    input bus_allow;
    begin
      case (cfg[`F_SP_HI:`F_SP_LO])
        `SP_EXT: layer_ev = ext_ev;
        `SP_BUS: layer_ev = bus_allow & bus_ev[cfg[`F_IN_HI:`F_IN_LO]];
        default: layer_ev = 1'b0;
      endcase
    end
  endfunction

  // Layer may proceed past its wait point
  function layer_go;
    input [`DATA_W-1:0] cfg;
    input first;
    input ev;
    begin
      layer_go = (cfg[`F_SP_HI:`F_SP_LO] == `SP_IMM) ||
        (cfg[`F_CTL] & first) || ev;
    end
  endfunction

  // Layer's spacing has an output side
  function wants_out;
    input [`DATA_W-1:0] cfg;
    begin
      wants_out = (cfg[`F_SP_HI:`F_SP_LO] == `SP_EXT) ||
        (cfg[`F_SP_HI:`F_SP_LO] == `SP_BUS);
    end
  endfunction

  assign raw_in = {bus_in, ext_trig_n};

  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi = gi + 1) begin : g_sync
      // Event only once the last two stages agree on the new level
      assign fall[gi] = stable_ff[gi] & ~sync2_ff[gi] & ~sync3_ff[gi];
      always @(posedge clk) begin
        if (rst) begin
          sync1_ff[gi] <= 1'b1;
          sync2_ff[gi] <= 1'b1;
          sync3_ff[gi] <= 1'b1;
          stable_ff[gi] <= 1'b1;
        end else begin
          sync1_ff[gi] <= raw_in[gi];
          sync2_ff[gi] <= sync1_ff[gi];
          sync3_ff[gi] <= sync2_ff[gi];
          if (sync2_ff[gi] == sync3_ff[gi]) begin
            stable_ff[gi] <= sync3_ff[gi];
          end
        end
      end
    end
  endgenerate

  assign step_cmd = wr && (addr == `REG_CTRL) && wdata[`CTRL_STEP];
  assign abort_cmd = wr && (addr == `REG_CTRL) && wdata[`CTRL_ABORT];
  assign clr_err = wr && (addr == `REG_CTRL) && wdata[`CTRL_CLR_ERR];
  assign mem_we = wr && (addr == `REG_LIST_DATA);

  // Scan and arm treat the bus as asynchronous; channel honours the mode
  assign arm_go = layer_go(arm_cfg_ff, arm_first_ff,
    layer_ev(arm_cfg_ff, fall[0], fall[NIN-1:1], 1'b1));
  assign scan_go = layer_go(scan_cfg_ff, scan_first_ff,
    layer_ev(scan_cfg_ff, fall[0], fall[NIN-1:1], 1'b1));
  assign chan_go = layer_go(chan_cfg_ff, chan_first_ff,
    layer_ev(chan_cfg_ff, fall[0], fall[NIN-1:1],
      ~chan_cfg_ff[`F_MODE]));

  // Zero channel count means use the list length
  assign chan_total = (chan_cfg_ff[`F_CNT_HI:`F_CNT_LO] == 8'h00) ?
    list_len_ff : {{(LIST_AW-7){1'b0}}, chan_cfg_ff[`F_CNT_HI:`F_CNT_LO]};
  assign nxt_idx = (({1'b0, chan_idx_ff} + 1'b1) >= list_len_ff) ?
    {LIST_AW{1'b0}} : chan_idx_ff + 1'b1;

  list_mem #(.DW(8), .AW(LIST_AW)) u_list (
    .clk(clk),
    .wr_en(mem_we),
    .wr_addr(list_ptr_ff),
    .wr_data(wdata[7:0]),
    .rd_addr(chan_idx_ff),
    .rd_data_ff(mem_q)
  );

  // Register writes; a bad line pair is refused and flagged
  always @(posedge clk) begin
    if (rst) begin
      arm_cfg_ff <= `ARM_CFG_RST;
      scan_cfg_ff <= `SCAN_CFG_RST;
      chan_cfg_ff <= `CHAN_CFG_RST;
      settle_ff <= 16'h0000;
      delay_ff <= 16'h0000;
      list_len_ff <= {(LIST_AW+1){1'b0}};
      list_ptr_ff <= {LIST_AW{1'b0}};
      cfg_err_ff <= 1'b0;
    end else begin
      if (clr_err) begin
        cfg_err_ff <= 1'b0;
      end
      if (wr) begin
        case (addr)
          `REG_ARM_CFG, `REG_SCAN_CFG, `REG_CHAN_CFG: begin
            if (!line_ok(wdata)) begin
              cfg_err_ff <= 1'b1;
            end else if (addr == `REG_ARM_CFG) begin
              arm_cfg_ff <= wdata;
            end else if (addr == `REG_SCAN_CFG) begin
              scan_cfg_ff <= wdata;
            end else begin
              chan_cfg_ff <= wdata;
            end
          end
          `REG_SETTLE: settle_ff <= wdata[15:0];
          `REG_DELAY: delay_ff <= wdata[15:0];
          `REG_LIST_LEN: list_len_ff <= wdata[LIST_AW:0];
          `REG_LIST_PTR: list_ptr_ff <= wdata[LIST_AW-1:0];
          `REG_LIST_DATA: list_ptr_ff <= list_ptr_ff + 1'b1;
          default: ;
        endcase
      end
    end
  end

  // Read data one cycle after the strobe; unmapped reads zero
  always @(posedge clk) begin
    if (rst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (rd) begin
      case (addr)
        `REG_CTRL: rdata_ff <= {28'h000_0000, state_ff};
        `REG_ARM_CFG: rdata_ff <= arm_cfg_ff;
        `REG_SCAN_CFG: rdata_ff <= scan_cfg_ff;
        `REG_CHAN_CFG: rdata_ff <= chan_cfg_ff;
        `REG_SETTLE: rdata_ff <= {16'h0000, settle_ff};
        `REG_DELAY: rdata_ff <= {16'h0000, delay_ff};
        `REG_LIST_LEN: rdata_ff <= {{(31-LIST_AW){1'b0}}, list_len_ff};
        `REG_LIST_PTR: rdata_ff <= {{(32-LIST_AW){1'b0}}, list_ptr_ff};
        `REG_STATUS: rdata_ff <= {23'h00_0000, cfg_err_ff, 8'h00} |
          {{(32-LIST_AW){1'b0}}, chan_idx_ff};
        default: rdata_ff <= 32'h0000_0000;
      endcase
    end else begin
      rdata_ff <= 32'h0000_0000;
    end
  end

  // Sequencer and output pulse generator
  always @(posedge clk) begin
    if (rst || abort_cmd) begin
      state_ff <= ST_IDLE;
      arm_first_ff <= 1'b0;
      scan_first_ff <= 1'b0;
      chan_first_ff <= 1'b0;
      arm_left_ff <= 8'h00;
      scan_left_ff <= 8'h00;
      chan_left_ff <= {(LIST_AW+1){1'b0}};
      chan_idx_ff <= {LIST_AW{1'b0}};
      timer_ff <= 17'h0_0000;
      pulse_cnt_ff <= 16'h0000;
      chan_ready_n_ff <= 1'b1;
      bus_out_ff <= {`NUM_LINES{1'b0}};
      bus_oe_ff <= {`NUM_LINES{1'b0}};
      chan_close_ff <= 1'b0;
      chan_num_ff <= 8'h00;
      idle_ff <= 1'b1;
    end else begin
      chan_close_ff <= 1'b0;
      idle_ff <= (state_ff == ST_IDLE);
      // Release the low pulse after its fixed width
      if (pulse_cnt_ff != 16'h0000) begin
        pulse_cnt_ff <= pulse_cnt_ff - 1'b1;
        if (pulse_cnt_ff == 16'h0001) begin
          chan_ready_n_ff <= 1'b1;
          bus_oe_ff <= {`NUM_LINES{1'b0}};
        end
      end
      case (state_ff)
        ST_IDLE: begin
          if (step_cmd) begin
            arm_first_ff <= 1'b1;
            arm_left_ff <= arm_cfg_ff[`F_CNT_HI:`F_CNT_LO];
            state_ff <= ST_ARM_W;
          end
        end
        ST_ARM_W: begin
          if (arm_go) begin
            arm_first_ff <= 1'b0;
            scan_first_ff <= 1'b1;
            scan_left_ff <= scan_cfg_ff[`F_CNT_HI:`F_CNT_LO];
            state_ff <= ST_SCAN_W;
          end
        end
        ST_SCAN_W: begin
          if (scan_go) begin
            scan_first_ff <= 1'b0;
            chan_first_ff <= 1'b1;
            chan_left_ff <= chan_total;
            chan_idx_ff <= {LIST_AW{1'b0}};
            state_ff <= ST_CHAN_W;
          end
        end
        ST_CHAN_W: begin
          if (chan_go) begin
            chan_first_ff <= 1'b0;
            state_ff <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          // List read data lands one cycle after the index
          state_ff <= ST_CLOSE;
        end
        ST_CLOSE: begin
          chan_close_ff <= 1'b1;
          chan_num_ff <= mem_q;
          timer_ff <= {1'b0, settle_ff} + {1'b0, delay_ff};
          state_ff <= ST_SETTLE;
        end
        ST_SETTLE: begin
          if (timer_ff != 17'h0_0000) begin
            timer_ff <= timer_ff - 1'b1;
          end else begin
            if (chan_cfg_ff[`F_SP_HI:`F_SP_LO] == `SP_EXT) begin
              chan_ready_n_ff <= 1'b0;
              pulse_cnt_ff <= PULSE_LEN;
            end else if (chan_cfg_ff[`F_SP_HI:`F_SP_LO] == `SP_BUS &&
                !chan_cfg_ff[`F_MODE]) begin
              bus_oe_ff[chan_cfg_ff[`F_OUT_HI:`F_OUT_LO]] <= 1'b1;
              pulse_cnt_ff <= PULSE_LEN;
            end
            state_ff <= ST_CHAN_OUT;
          end
        end
        ST_CHAN_OUT: begin
          if (pulse_cnt_ff == 16'h0000) begin
            chan_idx_ff <= nxt_idx;
            chan_left_ff <= chan_left_ff - 1'b1;
            if (chan_left_ff > {{LIST_AW{1'b0}}, 1'b1}) begin
              state_ff <= ST_CHAN_W;
            end else begin
              state_ff <= ST_SCAN_END;
            end
          end
        end
        ST_SCAN_END: begin
          if (scan_cfg_ff[`F_CTL] && wants_out(scan_cfg_ff)) begin
            pulse_cnt_ff <= PULSE_LEN;
            if (scan_cfg_ff[`F_SP_HI:`F_SP_LO] == `SP_EXT) begin
              chan_ready_n_ff <= 1'b0;
            end else begin
              bus_oe_ff[scan_cfg_ff[`F_OUT_HI:`F_OUT_LO]] <= 1'b1;
            end
          end
          state_ff <= ST_SCAN_OUT;
        end
        ST_SCAN_OUT: begin
          if (pulse_cnt_ff == 16'h0000) begin
            scan_left_ff <= scan_left_ff - 1'b1;
            if (scan_left_ff > 8'h01) begin
              state_ff <= ST_SCAN_W;
            end else begin
              state_ff <= ST_ARM_END;
            end
          end
        end
        ST_ARM_END: begin
          if (arm_cfg_ff[`F_CTL] && wants_out(arm_cfg_ff)) begin
            pulse_cnt_ff <= PULSE_LEN;
            if (arm_cfg_ff[`F_SP_HI:`F_SP_LO] == `SP_EXT) begin
              chan_ready_n_ff <= 1'b0;
            end else begin
              bus_oe_ff[arm_cfg_ff[`F_OUT_HI:`F_OUT_LO]] <= 1'b1;
            end
          end
          state_ff <= ST_ARM_OUT;
        end
        ST_ARM_OUT: begin
          if (pulse_cnt_ff == 16'h0000) begin
            arm_left_ff <= arm_left_ff - 1'b1;
            if (arm_left_ff > 8'h01) begin
              state_ff <= ST_ARM_W;
            end else begin
              state_ff <= ST_IDLE;
            end
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== testbench/seq_check_monitor.sv ====
// Port checker for the scan trigger sequencer
`timescale 1ns/10ps
`default_nettype none
`include "trig_seq_map.vh"
module seq_check_monitor #(
  parameter LIST_AW = 8,
  parameter PULSE_CYC = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [`DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic chan_ready_n_ff,
  input wire logic [`NUM_LINES-1:0] bus_out_ff,
  input wire logic [`NUM_LINES-1:0] bus_oe_ff,
  input wire logic chan_close_ff,
  input wire logic [7:0] chan_num_ff,
  input wire logic idle_ff
);
  logic [15:0] lo_ff;
  logic [15:0] oe_ff;
  // Pulse widths exceed any legal repetition count, so count them
  always @(posedge clk) begin
    if (rst) begin
      lo_ff <= 16'h0000;
      oe_ff <= 16'h0000;
    end else begin
      lo_ff <= chan_ready_n_ff ? 16'h0000 : lo_ff + 16'h0001;
      oe_ff <= (|bus_oe_ff) ? oe_ff + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_step;
    wr && addr == `REG_CTRL && wdata[`CTRL_STEP] && idle_ff;
  endsequence
  sequence s_gap;
    !chan_close_ff [*2];
  endsequence
  property p_ready_width;
    $rose(chan_ready_n_ff) |-> lo_ff == PULSE_CYC;
  endproperty
  a_ready_width: assert property (p_ready_width)
    else $error("channel ready pulse width wrong");
  property p_oe_width;
    $fell(|bus_oe_ff) |-> oe_ff == PULSE_CYC;
  endproperty
  a_oe_width: assert property (p_oe_width)
    else $error("bus output pulse width wrong");
  property p_out_zero;
    bus_out_ff == 6'h00;
  endproperty
  a_out_zero: assert property (p_out_zero)
    else $error("bus drive value not low");
  property p_oe_one;
    $countones(bus_oe_ff) <= 1;
  endproperty
  a_oe_one: assert property (p_oe_one)
    else $error("several bus lines driven at once");
  property p_close_gap;
    chan_close_ff |=> s_gap;
  endproperty
  a_close_gap: assert property (p_close_gap)
    else $error("channel closes too close together");
  property p_step_leave;
    s_step |=> ##1 !idle_ff;
  endproperty
  a_step_leave: assert property (p_step_leave)
    else $error("step did not leave idle");
  property p_pulse_busy;
    $fell(chan_ready_n_ff) |-> !idle_ff;
  endproperty
  a_pulse_busy: assert property (p_pulse_busy)
    else $error("output pulse while idle");
  property p_num_hold;
    !chan_close_ff |-> $stable(chan_num_ff);
  endproperty
  a_num_hold: assert property (p_num_hold)
    else $error("channel number moved without a close");
endmodule
bind scan_trigger_sequencer seq_check_monitor #(
  .LIST_AW(LIST_AW),
  .PULSE_CYC(PULSE_CYC)
) u_mon (
  .clk(clk),
  .rst(rst),
  .addr(addr),
  .wdata(wdata),
  .wr(wr),
  .chan_ready_n_ff(chan_ready_n_ff),
  .bus_out_ff(bus_out_ff),
  .bus_oe_ff(bus_oe_ff),
  .chan_close_ff(chan_close_ff),
  .chan_num_ff(chan_num_ff),
  .idle_ff(idle_ff)
);
`default_nettype wire

// ==== testbench/instr_model.sv ====
// Behavioural instrument answering each output trigger
`timescale 1ns/10ps
`default_nettype none
module instr_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic ready_n,
  input wire logic [5:0] bus_oe,
  input wire logic [15:0] lag,
  input wire logic use_bus,
  input wire logic [2:0] in_sel,
  input wire logic [2:0] out_sel,
  output logic trig_n,
  output logic [5:0] pull,
  output logic busy
);
  localparam logic [15:0] LOW_CYC = 16'h00fa;
  logic prev_rdy = 1'b1;
  logic prev_oe = 1'b0;
  logic [7:0] pend = 8'h00;
  logic [15:0] t = 16'h0000;
  logic req;
  logic low;
  assign req = use_bus ? (bus_oe[out_sel] & !prev_oe) : (!ready_n & prev_rdy);
  // Requests queue up; answers never overlap
  always @(posedge clk) begin
    if (rst) begin
      prev_rdy <= 1'b1;
      prev_oe <= 1'b0;
      pend <= 8'h00;
      t <= 16'h0000;
    end else begin
      prev_rdy <= ready_n;
      prev_oe <= bus_oe[out_sel];
      if (t != 16'h0000) begin
        t <= t - 16'h0001;
        pend <= pend + {7'h00, req};
      end else if (pend != 8'h00 || req) begin
        t <= lag + LOW_CYC;
        pend <= pend + {7'h00, req} - 8'h01;
      end
    end
  end
  // High for lag cycles, then low 2 us
  assign low = t != 16'h0000 && t <= LOW_CYC;
  assign trig_n = !(low && !use_bus);
  assign pull = (low && use_bus) ? (6'h01 << in_sel) : 6'h00;
  assign busy = pend != 8'h00 || t != 16'h0000;
endmodule
`default_nettype wire

// ==== testbench/scan_trigger_sequencer_tb.sv ====
// Self-checking bench for the scan trigger sequencer
`timescale 1ns/10ps
`default_nettype none
`include "trig_seq_map.vh"
module scan_trigger_sequencer_tb;
  localparam int PC = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [15:0] lag = 16'h0003;
  logic use_bus = 1'b0;
  logic [31:0] seed = 32'heca6_7fe8;
  wire [31:0] rdata;
  wire [7:0] num;
  wire [5:0] bus_in;
  wire [5:0] bus_oe;
  wire [5:0] pull;
  wire rdy_n;
  wire close;
  wire idle;
  wire trig_n;
  wire busy;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  int n_rdy = 0;
  int n_bus = 0;
  logic [31:0] exp_rd[$];
  logic [7:0] exp_ch[$];
  logic [7:0] list[3];
  logic rd_seen = 1'b0;
  logic rdy_d = 1'b1;
  logic [5:0] oe_d = 6'h00;
  always #4 clk = ~clk;
  // Open-drain lines with pull-up
  assign bus_in = ~(bus_oe | pull);
  scan_trigger_sequencer #(.PULSE_CYC(PC)) u_dut (.clk(clk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_ff(rdata),
    .ext_trig_n(trig_n), .chan_ready_n_ff(rdy_n), .bus_in(bus_in),
    .bus_out_ff(), .bus_oe_ff(bus_oe), .chan_close_ff(close),
    .chan_num_ff(num), .idle_ff(idle));
  instr_model u_inst (.clk(clk), .rst(rst), .ready_n(rdy_n),
    .bus_oe(bus_oe), .lag(lag), .use_bus(use_bus), .in_sel(3'h3),
    .out_sel(3'h2), .trig_n(trig_n), .pull(pull), .busy(busy));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_rd.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic run(input int id, input int ncl, input int nr, input int nb);
    int k;
    n_rdy = 0;
    n_bus = 0;
    for (k = 0; k < ncl; k++) exp_ch.push_back(list[k % 3]);
    wr_reg(`REG_CTRL, 32'h0000_0001);
    repeat (3) @(posedge clk);
    for (k = 0; k < 9000 && !(idle === 1'b1 && busy === 1'b0); k++)
      @(posedge clk);
    check(k < 9000, 1);
    check(n_rdy, nr);
    check(n_bus, nb);
    check(exp_ch.size(), 0);
    $display("test %0d done", id);
  endtask
  // Results are matched against notes in arrival order
  always @(posedge clk) begin
    rd_seen <= rd;
    rdy_d <= rdy_n;
    oe_d <= bus_oe;
    if (rd_seen) check(rdata, exp_rd.pop_front());
    if (!rst && close === 1'b1) begin
      if (exp_ch.size() == 0) check({24'h00_0000, num}, 32'hffff_ffff);
      else check({24'h00_0000, num}, {24'h00_0000, exp_ch.pop_front()});
    end
    if (!rst && rdy_d && !rdy_n) n_rdy++;
    if (!rst) n_bus += $countones(bus_oe & ~oe_d);
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  initial begin
    int k;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`REG_ARM_CFG, `ARM_CFG_RST);
    rd_chk(`REG_SCAN_CFG, `SCAN_CFG_RST);
    rd_chk(`REG_CHAN_CFG, `CHAN_CFG_RST);
    check(idle, 1);
    rd_chk(8'h40, 32'h0000_0000);
    // Same line both ways, then a line past #5
    for (k = 0; k < 2; k++) begin
      wr_reg(`REG_CHAN_CFG, k ? 32'h0006_0004 : 32'h0033_0005);
      rd_chk(`REG_CHAN_CFG, `CHAN_CFG_RST);
      rd_chk(`REG_STATUS, 32'h0000_0100);
      wr_reg(`REG_CTRL, 32'h0000_0004);
      rd_chk(`REG_STATUS, 32'h0000_0000);
    end
    $display("test 0 done");
    wr_reg(`REG_LIST_PTR, 32'h0000_0000);
    for (k = 0; k < 3; k++) begin
      seed = xs(seed);
      list[k] = seed[7:0];
      wr_reg(`REG_LIST_DATA, {24'h00_0000, list[k]});
    end
    wr_reg(`REG_LIST_LEN, 32'h0000_0003);
    seed = xs(seed);
    wr_reg(`REG_SETTLE, seed & 32'h0000_0007);
    seed = xs(seed);
    wr_reg(`REG_DELAY, seed & 32'h0000_0007);
    run(1, 3, 0, 0);
    wr_reg(`REG_CHAN_CFG, 32'h0001_0005);
    run(2, 3, 3, 0);
    use_bus <= 1'b1;
    lag <= 16'h0014;
    wr_reg(`REG_CHAN_CFG, 32'h0023_0006);
    run(3, 3, 0, 3);
    // Scan layer on the bus, reusing the channel layer's lines
    wr_reg(`REG_SCAN_CFG, 32'h0023_0206);
    run(4, 6, 0, 8);
    use_bus <= 1'b0;
    lag <= 16'h0028;
    wr_reg(`REG_CHAN_CFG, 32'h0001_0005);
    wr_reg(`REG_SCAN_CFG, 32'h0010_0205);
    run(5, 6, 8, 0);
    wr_reg(`REG_SCAN_CFG, `SCAN_CFG_RST);
    wr_reg(`REG_ARM_CFG, 32'h0010_0105);
    run(6, 3, 4, 0);
    print_verdict();
  end
endmodule
`default_nettype wire
